// *** rtl/css_pkg.sv ***
package css_pkg;

  // ==========================================
  // Widths
  // ==========================================
  localparam int MODE_W = 5;      // Link mode selection width
  localparam int MFLEN_W = 5; // Multiframe length field width
  localparam int CALSEL_W = 2;    // Calibration mode field width

  // ==========================================
  // Reset values and mode limit
  // ==========================================
  localparam logic [MODE_W-1:0] MODE_RST = 5'h00;
  localparam logic [MFLEN_W-1:0] MFLEN_RST = 5'h1f;
  localparam logic [MODE_W-1:0] MODE_MAX = 5'h13;  // Highest legal mode code

  // ==========================================
  // Timing counts
  // ==========================================
  localparam int CLK_MHZ = 125;                    // Clock rate in MHz
  localparam int CAL_TIME_NS = 800;                // Calibration run length
  localparam int CAL_CYC = (CAL_TIME_NS * CLK_MHZ + 999) / 1000;
  localparam int CAL_CNT_W = 8;
  localparam int ILA_MF = 4;                       // Multiframes of lane alignment

  // ==========================================
  // Enumerations
  // ==========================================
  typedef enum logic [2:0] {
    LNK_HALT,
    LNK_CGS,
    LNK_ILA,
    LNK_DATA
  } css_link_e;

  typedef enum logic [1:0] {
    CAL_HALT,
    CAL_IDLE,
    CAL_RUN
  } css_cal_e;

  // ==========================================
  // Carriers
  // ==========================================
  typedef struct packed {
    logic link_enable;
    logic cal_enable;
    logic [MODE_W-1:0] link_mode_select;
    logic [MFLEN_W-1:0] multiframe_len_minus_one;
    logic sync_from_timestamp;
    logic background_cal;
    logic offset_cal;
    logic overrange_enable;
    logic calib_software_trigger;
  } css_cfg_s;

  typedef struct packed {
    logic link_up;
    logic link_ila;
    logic cal_busy;
    logic cal_done;
    logic cfg_error;
  } css_stat_s;

endpackage : css_pkg

// *** rtl/css_sync2.sv ***
`timescale 1ns/1ps
// ==========================================
// Two-flop level synchroniser
// ==========================================
module css_sync2
(
  input wire logic clk,
  input wire logic resetn,
  input wire logic din,
  output logic dout
);

  typedef struct packed {
    logic meta;   // First stage, read only by the second
    logic stable; // Second stage
  } css_sync_s;

  css_sync_s s_reg;
  css_sync_s s_next;

  // Shift chain
  always_comb
  begin
    s_next.meta = din;
    s_next.stable = s_reg.meta;
  end

  // Register with synchronous reset to idle high
  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      s_reg <= '1;
    end
    else
    begin
      s_reg <= s_next;
    end
  end

  assign dout = s_reg.stable;

endmodule : css_sync2

// *** rtl/css_sequencer.sv ***
`timescale 1ns/1ps
// Behaviour
// - Link enable low halts link machine
// - Calibration enable low halts calibration machine
// - Sync source: single-ended or timestamp pair
// - Foreground/background calibration option; offset option latched but unused
// - Calibration enable high restarts calibration machine
// - Link enable high restarts link machine
// - Link advances by receiver sync signal
// - Trigger rising edge starts calibration run
module css_sequencer
#(
  parameter int CAL_CYCLES = css_pkg::CAL_CYC
)
(
  input wire logic clk,
  input wire logic resetn,
  input wire css_pkg::css_cfg_s cfg,
  input wire logic sync_se_n,
  input wire logic sync_ts_n,
  input wire logic high_supply_good,
  input wire logic overrange_in,
  output css_pkg::css_stat_s stat,
  output logic overrange_flag,
  output logic low_supply_enable,
  output logic [css_pkg::MODE_W-1:0] active_mode,
  output logic [css_pkg::MFLEN_W-1:0] active_mf_len
);

  // ==========================================
  // State
  // ==========================================
  typedef struct packed {
    css_pkg::css_link_e link;
    css_pkg::css_cal_e cal;
    logic [css_pkg::CAL_CNT_W-1:0] cal_cnt;   // Remaining run cycles
    logic [css_pkg::MFLEN_W+2:0] ila_cnt; // Frames left in alignment
    logic trig_prev;                          // Trigger history for edge
    logic [css_pkg::MODE_W-1:0] mode;         // Settings latched on restart
    logic [css_pkg::MFLEN_W-1:0] mf_len;
    logic sync_ts;
    logic bg_cal;
    logic ofs_cal;
    logic ovr_arm; // Registered overrange enable
    logic ovr;
    logic cal_done;
    logic cfg_err;
    logic low_en;
    logic up; // Link in data phase, kept as a flop for the output
    logic ila; // Link in alignment phase
    logic busy; // Calibration run in progress
  } css_state_s;

  css_state_s st_reg;
  css_state_s st_next;

  logic se_sync; // Synchronised single-ended sync, active low
  logic ts_sync; // Synchronised timestamp-pair sync, active low
  logic pg_sync; // Synchronised power good, active low
  logic ov_sync; // Synchronised overrange detector, active low
  logic sync_req; // Selected sync request, active high

  // ==========================================
  // Pin synchronisers
  // ==========================================
  css_sync2 u_sync_se (.clk(clk), .resetn(resetn), .din(sync_se_n), .dout(se_sync));
  css_sync2 u_sync_ts (.clk(clk), .resetn(resetn), .din(sync_ts_n), .dout(ts_sync));
  css_sync2 u_sync_pg (.clk(clk), .resetn(resetn), .din(~high_supply_good), .dout(pg_sync));
  css_sync2 u_sync_ov (.clk(clk), .resetn(resetn), .din(~overrange_in), .dout(ov_sync));

  // Frames per alignment phase, from the multiframe length
  function automatic logic [css_pkg::MFLEN_W+2:0] ila_len(
    input logic [css_pkg::MFLEN_W-1:0] mf_len
  );
    logic [css_pkg::MFLEN_W+2:0] k;
    k = {3'h0, mf_len} + {{(css_pkg::MFLEN_W+2){1'b0}}, 1'b1};
    ila_len = k * 3'(css_pkg::ILA_MF);
  endfunction : ila_len

  // Source chosen by the latched select; stale value while halted is harmless
  assign sync_req = st_reg.sync_ts ? ~ts_sync : ~se_sync;

  // ==========================================
  // Next-state logic
  // ==========================================
  always_comb
  begin
    st_next = st_reg;
    st_next.trig_prev = cfg.calib_software_trigger;

    // Low supply follows good power, three clocks behind on both rise and loss
    st_next.low_en = ~pg_sync;

    // Link machine
    unique case (st_reg.link)
      css_pkg::LNK_HALT:
      begin
        // Settings accepted only while halted, taken at restart
        if (cfg.link_enable)
        begin
          st_next.mode = cfg.link_mode_select;
          st_next.mf_len = cfg.multiframe_len_minus_one;
          st_next.sync_ts = cfg.sync_from_timestamp;
          st_next.cfg_err = (cfg.link_mode_select > css_pkg::MODE_MAX);
          st_next.link = css_pkg::LNK_CGS;
        end
      end
      css_pkg::LNK_CGS:
      begin
        // Leave code-group sync when receiver releases its request
        if (!sync_req)
        begin
          st_next.link = css_pkg::LNK_ILA;
          st_next.ila_cnt = ila_len(st_reg.mf_len);
        end
      end
      css_pkg::LNK_ILA:
      begin
        if (sync_req)
          st_next.link = css_pkg::LNK_CGS;
        else if (st_reg.ila_cnt <= 8'(1))
          st_next.link = css_pkg::LNK_DATA;
        else
          st_next.ila_cnt = st_reg.ila_cnt - 8'(1);
      end
      css_pkg::LNK_DATA:
      begin
        // Resync request drops back to code-group sync
        if (sync_req)
          st_next.link = css_pkg::LNK_CGS;
      end
      default:
        st_next.link = css_pkg::LNK_HALT;
    endcase
    if (!cfg.link_enable)
      st_next.link = css_pkg::LNK_HALT;

    // Calibration machine
    unique case (st_reg.cal)
      css_pkg::CAL_HALT:
      begin
        if (cfg.cal_enable)
        begin
          st_next.bg_cal = cfg.background_cal;
          st_next.ofs_cal = cfg.offset_cal;
          st_next.cal = css_pkg::CAL_IDLE;
        end
      end
      css_pkg::CAL_IDLE:
      begin
        // Only a rising trigger starts a run; a held 1 does not retrigger
        if (cfg.calib_software_trigger && !st_reg.trig_prev)
        begin
          st_next.cal = css_pkg::CAL_RUN;
          st_next.cal_cnt = css_pkg::CAL_CNT_W'(CAL_CYCLES);
          st_next.cal_done = 1'b0;
        end
      end
      css_pkg::CAL_RUN:
      begin
        if (st_reg.cal_cnt <= css_pkg::CAL_CNT_W'(1))
        begin
          // Background mode keeps tracking; foreground returns to idle
          st_next.cal = st_reg.bg_cal ? css_pkg::CAL_RUN : css_pkg::CAL_IDLE;
          st_next.cal_cnt = css_pkg::CAL_CNT_W'(CAL_CYCLES);
          st_next.cal_done = 1'b1;
        end
        else
          st_next.cal_cnt = st_reg.cal_cnt - css_pkg::CAL_CNT_W'(1);
      end
      default:
        st_next.cal = css_pkg::CAL_HALT;
    endcase
    if (!cfg.cal_enable)
    begin
      st_next.cal = css_pkg::CAL_HALT;
      st_next.cal_done = 1'b0;
    end

    // Overrange detection, enable may change any time
    st_next.ovr_arm = cfg.overrange_enable;
    st_next.ovr = st_reg.ovr_arm & ~ov_sync;

    // Status decoded ahead of the register so outputs leave straight from flops
    st_next.up = (st_next.link == css_pkg::LNK_DATA);
    st_next.ila = (st_next.link == css_pkg::LNK_ILA);
    st_next.busy = (st_next.cal == css_pkg::CAL_RUN);
  end

  // ==========================================
  // State register
  // ==========================================
  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      // Everything halted after reset; host then configures
      st_reg <= '0;
      st_reg.link <= css_pkg::LNK_HALT;
      st_reg.cal <= css_pkg::CAL_HALT;
      st_reg.mode <= css_pkg::MODE_RST;
      st_reg.mf_len <= css_pkg::MFLEN_RST;
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  // ==========================================
  // Outputs, all from flops
  // ==========================================
  assign stat.link_up = st_reg.up;
  assign stat.link_ila = st_reg.ila;
  assign stat.cal_busy = st_reg.busy;
  assign stat.cal_done = st_reg.cal_done;
  assign stat.cfg_error = st_reg.cfg_err;
  assign overrange_flag = st_reg.ovr;
  assign low_supply_enable = st_reg.low_en;
  assign active_mode = st_reg.mode;
  assign active_mf_len = st_reg.mf_len;

endmodule : css_sequencer

// *** sim/css_seq_assertions.sv ***
`timescale 1ns/1ps
// ==========================================
// Startup sequencer checks
// ==========================================
module css_seq_assertions
#(
  parameter int CAL_CYCLES = css_pkg::CAL_CYC
)
(
  input wire logic clk,
  input wire logic resetn,
  input wire css_pkg::css_cfg_s cfg,
  input wire logic sync_se_n,
  input wire logic sync_ts_n,
  input wire logic high_supply_good,
  input wire css_pkg::css_stat_s stat,
  input wire logic low_supply_enable,
  input wire logic [css_pkg::MODE_W-1:0] active_mode,
  input wire logic [css_pkg::MFLEN_W-1:0] active_mf_len
);
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  logic [7:0] ila_cnt;  // Alignment cycles so far
  logic [7:0] busy_cnt;  // Calibration cycles so far
  // Run lengths, counted since the repeat operator cannot take a variable
  always_ff @(posedge clk)
  begin
    ila_cnt <= (resetn && stat.link_ila) ? ila_cnt + 8'h01 : 8'h00;
    busy_cnt <= (resetn && stat.cal_busy) ? busy_cnt + 8'h01 : 8'h00;
  end
  property p_link_halt;
    !cfg.link_enable |=> !stat.link_up && !stat.link_ila;
  endproperty
  a_link_halt: assert property (p_link_halt) else $error("link runs while off");
  property p_cal_halt;
    !cfg.cal_enable |=> !stat.cal_busy && !stat.cal_done;
  endproperty
  a_cal_halt: assert property (p_cal_halt) else $error("cal runs while off");
  property p_sync_sel;
    $rose(stat.link_ila) |->
      (cfg.sync_from_timestamp ? $past(sync_ts_n, 3) : $past(sync_se_n, 3));
  endproperty
  a_sync_sel: assert property (p_sync_sel) else $error("wrong sync source");
  property p_latch;
    $rose(cfg.link_enable) |=> active_mode == $past(cfg.link_mode_select)
      && active_mf_len == $past(cfg.multiframe_len_minus_one)
      && stat.cfg_error == ($past(cfg.link_mode_select) > css_pkg::MODE_MAX);
  endproperty
  a_latch: assert property (p_latch) else $error("restart settings wrong");
  property p_ila_len;
    $rose(stat.link_up) |-> ila_cnt == (({3'h0, active_mf_len} + 8'h01) << 2);
  endproperty
  a_ila_len: assert property (p_ila_len) else $error("alignment length wrong");
  property p_cal_start;
    $rose(cfg.calib_software_trigger) && cfg.cal_enable && $past(cfg.cal_enable)
      && !stat.cal_busy |=> stat.cal_busy;
  endproperty
  a_cal_start: assert property (p_cal_start) else $error("trigger ignored");
  property p_cal_len;
    $fell(stat.cal_busy) && cfg.cal_enable && $past(cfg.cal_enable) |->
      busy_cnt == CAL_CYCLES && stat.cal_done;
  endproperty
  a_cal_len: assert property (p_cal_len) else $error("cal run length wrong");
  property p_supply;
    (high_supply_good [*4] |-> low_supply_enable)
      and (!high_supply_good [*4] |-> !low_supply_enable);
  endproperty
  a_supply: assert property (p_supply) else $error("low supply misordered");
  cover property ($rose(stat.link_up));
  cover property ($rose(stat.cal_done));
  cover property ($rose(stat.cfg_error));
endmodule : css_seq_assertions

bind css_sequencer css_seq_assertions #(.CAL_CYCLES(CAL_CYCLES)) u_chk (.clk(clk),
  .resetn(resetn), .cfg(cfg), .sync_se_n(sync_se_n), .sync_ts_n(sync_ts_n),
  .high_supply_good(high_supply_good), .stat(stat), .low_supply_enable(low_supply_enable),
  .active_mode(active_mode), .active_mf_len(active_mf_len));

// *** sim/css_host_model.sv ***
`timescale 1ns/1ps
// ==========================================
// Host controller: one setting per edge, in order
// ==========================================
module css_host_model
(
  input wire logic clk,
  output css_pkg::css_cfg_s cfg
);
  // All off until the bench has reset the part
  initial cfg = '0;
  // Full restart in the listed order; bg picks background calibration
  task automatic bring_up(input logic [4:0] mode, input logic [4:0] mf_len, input logic ts,
    input logic bg);
    @(posedge clk) cfg.link_enable <= 1'b0;
    @(posedge clk) cfg.cal_enable <= 1'b0;
    @(posedge clk) cfg.link_mode_select <= mode;
    @(posedge clk) cfg.multiframe_len_minus_one <= mf_len;
    @(posedge clk) cfg.sync_from_timestamp <= ts;
    @(posedge clk) cfg.background_cal <= bg;
    @(posedge clk) cfg.offset_cal <= 1'b1;
    @(posedge clk) cfg.cal_enable <= 1'b1;
    @(posedge clk) cfg.overrange_enable <= 1'b1;
    @(posedge clk) cfg.link_enable <= 1'b1;
  endtask : bring_up
  // Low then high gives the rising edge
  task automatic fire_cal();
    @(posedge clk) cfg.calib_software_trigger <= 1'b0;
    @(posedge clk) cfg.calib_software_trigger <= 1'b1;
  endtask : fire_cal
endmodule : css_host_model

// *** sim/tb_css_sequencer.sv ***
`timescale 1ns/1ps
// ==========================================
// Bench: host model drives, receiver pins from here
// ==========================================
module tb_css_sequencer;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic sync_se_n = 1'b0;  // Receiver requesting sync
  logic sync_ts_n = 1'b0;
  logic high_supply_good = 1'b0;
  logic overrange_in = 1'b0;
  css_pkg::css_cfg_s cfg;
  css_pkg::css_stat_s stat;
  logic overrange_flag;
  logic low_supply_enable;
  logic [4:0] active_mode;
  logic [4:0] active_mf_len;
  int bad_count = 0;
  int samples_checked = 0;
  int cycles = 0;
  always #4 clk = ~clk;
  css_host_model u_host (.clk(clk), .cfg(cfg));
  css_sequencer #(.CAL_CYCLES(4)) u_dut (.clk(clk), .resetn(resetn), .cfg(cfg),
    .sync_se_n(sync_se_n), .sync_ts_n(sync_ts_n), .high_supply_good(high_supply_good),
    .overrange_in(overrange_in), .stat(stat), .overrange_flag(overrange_flag),
    .low_supply_enable(low_supply_enable), .active_mode(active_mode),
    .active_mf_len(active_mf_len));
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic wrap_up();
    if (bad_count == 0 && samples_checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : wrap_up
  // Sample at the falling edge, clear of updates
  task automatic tick(input int n);
    repeat (n) @(negedge clk);
  endtask : tick
  // Bounded wait; longest alignment is 128 cycles
  task automatic wait_up();
    for (int k = 0; k < 200 && stat.link_up !== 1'b1; k++) tick(1);
  endtask : wait_up
  // Hang guard
  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 3000)
    begin
      bad_count++;
      wrap_up();
    end
  end
  initial
  begin
    tick(20);
    @(posedge clk) resetn <= 1'b1;
    tick(1);
    check("mf len reset", active_mf_len, 8'h1f);
    @(posedge clk) high_supply_good <= 1'b1;
    tick(5);
    check("low on", low_supply_enable, 8'h01);
    @(posedge clk) high_supply_good <= 1'b0;
    tick(5);
    check("low off", low_supply_enable, 8'h00);
    @(posedge clk) high_supply_good <= 1'b1;
    u_host.bring_up(5'h04, 5'h01, 1'b0, 1'b0);
    tick(8);
    check("mode", active_mode, 8'h04);
    check("mf len", active_mf_len, 8'h01);
    check("held in sync", stat.link_ila, 8'h00);
    @(posedge clk) sync_se_n <= 1'b1;
    wait_up();
    check("up se", stat.link_up, 8'h01);
    @(posedge clk) overrange_in <= 1'b1;
    tick(5);
    check("overrange", overrange_flag, 8'h01);
    u_host.fire_cal();
    for (int k = 0; k < 40 && stat.cal_done !== 1'b1; k++) tick(1);
    check("cal done", stat.cal_done, 8'h01);
    // Timestamp pair selected, single-ended pin requesting again
    @(posedge clk) sync_se_n <= 1'b0;
    u_host.bring_up(5'h14, 5'h00, 1'b1, 1'b0);
    tick(2);
    check("cal cleared", stat.cal_done, 8'h00);
    check("bad mode", stat.cfg_error, 8'h01);
    @(posedge clk) sync_ts_n <= 1'b1;
    wait_up();
    check("up ts", stat.link_up, 8'h01);
    @(posedge clk) sync_se_n <= 1'b1;
    u_host.bring_up(5'h13, 5'h1f, 1'b0, 1'b1);
    tick(2);
    check("top mode", stat.cfg_error, 8'h00);
    wait_up();
    check("up long", stat.link_up, 8'h01);
    // Background calibration keeps running after its first pass
    u_host.fire_cal();
    tick(12);
    check("bg busy", stat.cal_busy, 8'h01);
    check("bg done", stat.cal_done, 8'h01);
    wrap_up();
  end
endmodule : tb_css_sequencer
